/* File: src/bdsa_consts.vh */
`ifndef BDSA_CONSTS_VH
`define BDSA_CONSTS_VH

// ----------------------------------------------------------------
// Address window and timing constants.
// ----------------------------------------------------------------
`define BDSA_ADDR_W        23
`define BDSA_REG_BASE      23'h7fff00
`define BDSA_REG_LAST      23'h7fff0b
`define BDSA_TABLE_LAST    23'h7fffff
`define BDSA_SEC_BASE      23'h7fffc0
`define BDSA_RELEASE_NS    300
`define BDSA_CLK_NS        100
`define BDSA_RELEASE_CYC   ((`BDSA_RELEASE_NS + `BDSA_CLK_NS - 1) / `BDSA_CLK_NS)

// ----------------------------------------------------------------
// Breakpoint kinds.
// ----------------------------------------------------------------
`define BDSA_BRK_TAG       1'h0
`define BDSA_BRK_FORCE     1'h1

`endif

/* File: src/bdsa_core.v */
`include "bdsa_consts.vh"

module bdsa_core #(
	parameter RELEASE_CYC = `BDSA_RELEASE_CYC
) (
	// Clock and reset.
	input  wire        sys_clk,
	input  wire        rst_n,
	// Chip mode and security.
	input  wire        specialMode,
	input  wire        securedAtReset,
	// Erase check result from secure firmware.
	input  wire        eraseCheckDone,
	input  wire        eraseCheckPass,
	// Serial interface hardware commands.
	input  wire        hwByteWriteCommand,
	input  wire [7:0]  hwWriteData,
	input  wire        hwEnterDebug,
	input  wire        unsecureRequest,
	input  wire        fwCommandReq,
	// Processor activation sources.
	input  wire        enterDebugInstruction,
	input  wire        extTag,
	input  wire        breakpointHit,
	input  wire        breakpointKind,
	input  wire        instrDone,
	input  wire        debugExit,
	// Address decode.
	input  wire [22:0] addr,
	input  wire        addrValid,
	input  wire        fromDebug,
	// Status and control outputs.
	output reg         debug_enable_bit,
	output reg         unsecure_flag,
	output reg         debugActive,
	output reg         secureTableOn,
	output reg         cpuHold,
	output reg         enterBeforeNext,
	output wire        fwCommandAccept,
	output wire        hwCommandAccept,
	output wire        regHit,
	output wire        tableHit,
	output wire        secTableHit,
	output wire        regBlocked
);

	// ----------------------------------------------------------------
	// State encoding.
	// ----------------------------------------------------------------
	localparam S_IDLE    = 5'h01;
	localparam S_PEND    = 5'h02;
	localparam S_ACTIVE  = 5'h04;
	localparam S_RELEASE = 5'h08;
	localparam S_SECLOOP = 5'h10;

	reg  [4:0] state;
	reg  [4:0] next_state;
	reg  [7:0] relCount;
	reg        modeSync1;
	reg        modeSync;
	reg        secSync1;
	reg        secSync;
	reg  [1:0] startCount;
	wire       debugAllowed;
	wire       cpuSource;
	wire       anySource;

	// ----------------------------------------------------------------
	// Strap synchronisers.
	// ----------------------------------------------------------------
	// Mode and security straps pass two flip-flops; only the second stage is read.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			modeSync1 <= 1'h0;
			modeSync  <= 1'h0;
			secSync1  <= 1'h0;
			secSync   <= 1'h0;
		end else begin
			modeSync1 <= specialMode;
			modeSync  <= modeSync1;
			secSync1  <= securedAtReset;
			secSync   <= secSync1;
		end
	end

	// ----------------------------------------------------------------
	// Command gating.
	// ----------------------------------------------------------------
	// Secured parts allow debug only in special mode.
	assign debugAllowed = unsecure_flag | modeSync;
	assign cpuSource    = enterDebugInstruction | extTag | breakpointHit;
	assign anySource    = cpuSource | hwEnterDebug;

	// Hardware commands pass unless the part is locked out.
	assign hwCommandAccept = debugAllowed;
	// Firmware commands need active mode and an unsecured part.
	assign fwCommandAccept = fwCommandReq & debugActive & unsecure_flag
		& (state == S_ACTIVE);

	// ----------------------------------------------------------------
	// Activation sequencer.
	// ----------------------------------------------------------------
	// Next state of the activation sequencer.
	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (debug_enable_bit && debugAllowed && anySource)
					next_state = S_PEND;
				else if (!debug_enable_bit && cpuSource)
					next_state = S_RELEASE;
			end
			S_PEND: begin
				if (instrDone)
					next_state = S_ACTIVE;
			end
			S_ACTIVE: begin
				if (secureTableOn && eraseCheckDone && !eraseCheckPass)
					next_state = S_SECLOOP;
				else if (debugExit && !secureTableOn)
					next_state = S_IDLE;
			end
			S_RELEASE: begin
				if (relCount == 8'h00)
					next_state = S_IDLE;
			end
			S_SECLOOP: begin
				next_state = S_SECLOOP;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// Sequencer, flags and the reset entry into debug mode.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state            <= S_IDLE;
			relCount         <= 8'h00;
			startCount       <= 2'h0;
			debug_enable_bit <= 1'h0;
			unsecure_flag    <= 1'h0;
			debugActive      <= 1'h0;
			secureTableOn    <= 1'h0;
			cpuHold          <= 1'h0;
			enterBeforeNext  <= 1'h0;
		end else begin
			state <= next_state;
			// The straps are trusted only once both synchroniser stages hold them.
			if (startCount != 2'h3)
				startCount <= startCount + 2'h1;
			// The third edge after release decides the reset entry.
			if (startCount == 2'h2) begin
				unsecure_flag <= ~secSync;
			end
			if (startCount == 2'h2 && modeSync) begin
				debug_enable_bit <= 1'h1;
				debugActive      <= 1'h1;
				secureTableOn    <= secSync;
				cpuHold          <= 1'h1;
				state            <= S_ACTIVE;
			end else begin
				// Erase check outcome while the secure table is in.
				if (secureTableOn && eraseCheckDone) begin
					debug_enable_bit <= 1'h1;
					if (eraseCheckPass) begin
						unsecure_flag <= 1'h1;
						secureTableOn <= 1'h0;
					end
				end
				// Host sets enable through a byte write to status.
				if (hwByteWriteCommand && debugAllowed && hwWriteData[7])
					debug_enable_bit <= 1'h1;
				else if (hwByteWriteCommand && debugAllowed && !secureTableOn)
					debug_enable_bit <= 1'h0;
				// Unsecure over serial only in special mode.
				if (unsecureRequest && modeSync)
					unsecure_flag <= 1'h1;
				debugActive <= (next_state == S_ACTIVE) || (next_state == S_SECLOOP);
				cpuHold     <= (next_state == S_PEND) || (next_state == S_RELEASE)
					|| (next_state == S_ACTIVE) || (next_state == S_SECLOOP);
			end
			// Breakpoint kind decides entry before or after the next instruction.
			if (state == S_IDLE && breakpointHit)
				enterBeforeNext <= (breakpointKind == `BDSA_BRK_FORCE);
			// Delay counter for refused activations.
			if (state == S_IDLE)
				relCount <= RELEASE_CYC[7:0];
			else if (state == S_RELEASE && relCount != 8'h00)
				relCount <= relCount - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Window decode.
	// ----------------------------------------------------------------
	// Register and table window decode.
	bdsa_decode u_decode (
		.addr          (addr),
		.addrValid     (addrValid),
		.fromDebug     (fromDebug),
		.debugActive   (debugActive),
		.secureTableOn (secureTableOn),
		.regHit        (regHit),
		.tableHit      (tableHit),
		.secTableHit   (secTableHit),
		.regBlocked    (regBlocked)
	);

endmodule // bdsa_core

/* File: src/bdsa_decode.v */
`include "bdsa_consts.vh"

module bdsa_decode (
	// Access request.
	input  wire [22:0] addr,
	input  wire        addrValid,
	input  wire        fromDebug,
	// Mode state.
	input  wire        debugActive,
	input  wire        secureTableOn,
	// Decode results.
	output wire        regHit,
	output wire        tableHit,
	output wire        secTableHit,
	output wire        regBlocked
);

	wire inRegs;
	wire inTable;

	// Ranges of the register block and the firmware table.
	assign inRegs      = (addr >= `BDSA_REG_BASE) && (addr <= `BDSA_REG_LAST);
	assign inTable     = (addr > `BDSA_REG_LAST) && (addr <= `BDSA_TABLE_LAST);

	// Window is decoded only while debug mode is active.
	assign regHit      = addrValid & debugActive & inRegs & fromDebug;
	assign regBlocked  = addrValid & debugActive & inRegs & ~fromDebug;
	assign tableHit    = addrValid & debugActive & inTable;
	assign secTableHit = tableHit & secureTableOn & (addr >= `BDSA_SEC_BASE);

endmodule // bdsa_decode

/* File: test/background_debug_security_activation_test.sv */
`include "bdsa_consts.vh"
module background_debug_security_activation_test;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus, pulses and observed outputs.
	logic sys_clk = 0, rst_n = 0, specialMode = 0, securedAtReset = 0, eraseCheckPass = 0;
	logic fwCommandReq = 0, breakpointKind = 0, addrValid = 0, fromDebug = 0, go = 0, b;
	logic [7:0] val = 8'h00, p = 8'h00;
	logic [22:0] addr = 23'h000000;
	wire logic hwByteWriteCommand;
	wire logic [7:0] hwWriteData;
	logic debug_enable_bit, unsecure_flag, debugActive, secureTableOn, cpuHold, regHit;
	logic enterBeforeNext, fwCommandAccept, hwCommandAccept, tableHit, secTableHit, regBlocked;
	int num_errors = 0, num_checks = 0, cyc = 0, n, k;
	always #50 sys_clk = ~sys_clk;
	bdsa_core bdsa_core_inst (.*, .hwEnterDebug(p[0]), .enterDebugInstruction(p[1]),
		.extTag(p[2]), .breakpointHit(p[3]), .instrDone(p[4]), .debugExit(p[5]),
		.eraseCheckDone(p[6]), .unsecureRequest(p[7]));
	bdsa_host bdsa_host_inst (.sys_clk(sys_clk), .go(go), .val(val),
		.hwByteWriteCommand(hwByteWriteCommand), .hwWriteData(hwWriteData));
	// Shared helpers for waits, pulses, probes and comparisons.
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch at %0t: saw %0h expected %0h", $time, s, e);
		end
	endtask
	task automatic w(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	task automatic pulse(input int i);
		@(posedge sys_clk) p <= 8'h01 << i;
		@(posedge sys_clk) p <= 8'h00;
	endtask
	task automatic probe(input logic [22:0] a, input logic d);
		@(posedge sys_clk) addr <= a;
		addrValid <= 1;
		fromDebug <= d;
		w(1);
	endtask
	task automatic rst(input logic sp, se);
		@(posedge sys_clk) rst_n <= 0;
		specialMode <= sp;
		securedAtReset <= se;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1;
		w(4);
	endtask
	task automatic hw(input logic [7:0] v);
		@(posedge sys_clk) go <= 1;
		val <= v;
		@(posedge sys_clk) go <= 0;
		w(2);
	endtask
	task automatic held(input int i, input logic [31:0] e);
		pulse(i);
		#1;
		n = (cpuHold === 1'b1);
		repeat (7) begin
			w(1);
			n += (cpuHold === 1'b1);
		end
		chk(n, e);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			final_report();
		end
	end
	// Main sequence.
	initial begin
		void'($urandom(32'hd535));
		rst(0, 0);
		@(posedge sys_clk) fwCommandReq <= 1;
		w(1);
		chk({debug_enable_bit, debugActive, fwCommandAccept}, 3'b000);
		held(0, 0);
		held(1, `BDSA_RELEASE_CYC + 1);
		chk(debugActive, 0);
		hw(8'h80);
		chk(debug_enable_bit, 1);
		for (k = 0; k < 4; k++) begin
			b = $urandom % 2;
			@(posedge sys_clk) breakpointKind <= b;
			pulse(k);
			w(3);
			chk(cpuHold, 1);
			if (k == 3) chk(enterBeforeNext, b);
			pulse(4);
			w(2);
			chk({debugActive, fwCommandAccept}, 2'b11);
			probe(23'h7fff00 + $urandom % 12, 1);
			chk(regHit, 1);
			probe(23'h7fff0c, 1);
			chk(regHit, 0);
			chk(tableHit, 1);
			probe(23'h7fff00 + k, 0);
			chk(regBlocked, 1);
			pulse(5);
			w(2);
			chk({debugActive, regHit, regBlocked}, 3'b000);
		end
		rst(1, 0);
		chk({debug_enable_bit, debugActive}, 2'b11);
		for (k = 0; k < 2; k++) begin
			rst(1, 1);
			chk({secureTableOn, unsecure_flag}, 2'b10);
			@(posedge sys_clk) eraseCheckPass <= k[0];
			pulse(6);
			w(2);
			chk({unsecure_flag, debug_enable_bit, secureTableOn}, {k[0], 1'b1, ~k[0]});
			chk({hwCommandAccept, fwCommandAccept}, {1'b1, k[0]});
			probe(`BDSA_SEC_BASE, 1);
			chk(secTableHit, !k[0]);
			pulse(7);
			w(1);
			chk(unsecure_flag, 1);
		end
		rst(0, 1);
		hw(8'h80);
		pulse(7);
		pulse(1);
		pulse(4);
		w(2);
		chk({debugActive, unsecure_flag, debug_enable_bit, hwCommandAccept}, 4'h0);
		final_report();
	end
endmodule // background_debug_security_activation_test

/* File: test/bdsa_checker_assertions.sv */
module bdsa_checker #(parameter int RELEASE_CYC = 3) (
	// Observed ports.
	input wire logic sys_clk, rst_n, debug_enable_bit, unsecure_flag, debugActive,
	input wire logic secureTableOn, cpuHold, enterBeforeNext, fwCommandAccept,
	input wire logic regHit, regBlocked, hwEnterDebug, breakpointHit, breakpointKind,
	input wire logic instrDone, fromDebug,
	input wire logic [22:0] addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// All checks share the bus clock and its reset.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	reg_window_a: assert property (regHit |-> debugActive
		&& addr >= 23'h7fff00 && addr <= 23'h7fff0b) else $error("hit outside window");
	user_block_a: assert property (regBlocked |-> !fromDebug && debugActive)
		else $error("block without user access");
	fw_gate_a: assert property (fwCommandAccept |-> debugActive && unsecure_flag)
		else $error("firmware command taken while locked");
	ignore_cmd_a: assert property (!debug_enable_bit && !cpuHold && hwEnterDebug
		|=> !cpuHold) else $error("stall on ignored command");
	brief_hold_a: assert property ($rose(cpuHold) && !debug_enable_bit
		|-> ##RELEASE_CYC cpuHold ##1 !cpuHold) else $error("hold length wrong");
	kind_select_a: assert property ($rose(cpuHold) && debug_enable_bit && $past(breakpointHit)
		|-> enterBeforeNext == $past(breakpointKind)) else $error("breakpoint kind lost");
	done_enter_a: assert property (cpuHold && debug_enable_bit && instrDone
		|=> debugActive) else $error("no entry after instruction");
	unlock_a: assert property ($fell(secureTableOn) |-> unsecure_flag && debug_enable_bit)
		else $error("overlay dropped while locked");
	cover property ($rose(debugActive));
	cover property ($fell(secureTableOn));
	cover property ($fell(cpuHold) && !debug_enable_bit);
endmodule // bdsa_checker
bind bdsa_core bdsa_checker #(.RELEASE_CYC(RELEASE_CYC)) bdsa_checker_inst (.*);

/* File: test/bdsa_host.sv */
module bdsa_host (
	// Clock and requests from the bench.
	input  wire logic       sys_clk,
	input  wire logic       go,
	input  wire logic [7:0] val,
	// Hardware command towards the device.
	output logic            hwByteWriteCommand,
	output logic [7:0]      hwWriteData
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {hwByteWriteCommand, hwWriteData} = 9'h000;
	// A byte write lasts one cycle; data outside it is scrambled so it is never relied on.
	always @(posedge sys_clk) begin
		hwByteWriteCommand <= go;
		hwWriteData <= go ? val : ~hwWriteData;
	end
endmodule // bdsa_host
